/* core/rpm_pkg.sv */
// Shared constants, types and register map for the reset and power mode block
package rpm_pkg;

	// Printed register indices; byte address is four times the index
	localparam logic [7:0]  RPM_IDX_FLAGS   = 8'h0f;
	localparam logic [7:0]  RPM_IDX_MODE    = 8'h20;
	localparam logic [7:0]  RPM_IDX_T1CON   = 8'h2a;
	localparam logic [7:0]  RPM_IDX_WAKE    = 8'h34;
	localparam logic [11:0] RPM_ADDR_FLAGS  = {2'h0, RPM_IDX_FLAGS, 2'h0};
	localparam logic [11:0] RPM_ADDR_MODE   = {2'h0, RPM_IDX_MODE, 2'h0};
	localparam logic [11:0] RPM_ADDR_T1CON  = {2'h0, RPM_IDX_T1CON, 2'h0};
	localparam logic [11:0] RPM_ADDR_WAKE   = {2'h0, RPM_IDX_WAKE, 2'h0};
	// Command and status words
	localparam logic [11:0] RPM_ADDR_CMD    = 12'h100;
	localparam logic [11:0] RPM_ADDR_STAT   = 12'h104;

	// Field positions
	localparam int RPM_FLAG_TO   = 7;   // Timeout-n flag
	localparam int RPM_FLAG_PD   = 6;   // Powerdown-n flag
	localparam int RPM_MS0       = 0;   // Speed select bit
	localparam int RPM_MS1       = 1;   // Standby kind bit
	localparam int RPM_TIMER1_WAKE_ENABLE    = 7;   // Timer 1 wake enable
	localparam int RPM_CMD_STBY  = 0;   // Standby instruction strobe
	localparam int RPM_CMD_WATCHDOG_CLEAR_INSTRUCTION  = 1;   // Watchdog clear strobe

	// Implemented bits of each register; for flags, the bus-writable bits only
	localparam logic [7:0] RPM_FLAGS_WMASK = 8'h3f;
	localparam logic [7:0] RPM_MODE_MASK   = 8'h07;
	localparam logic [7:0] RPM_T1CON_MASK  = 8'h9b;
	localparam logic [7:0] RPM_WAKE_MASK   = 8'hff;

	// Reset values
	localparam logic [7:0]  RPM_FLAGS_RST   = 8'hc0;
	localparam logic [7:0]  RPM_MODE_RST    = 8'h00;
	localparam logic [7:0]  RPM_T1CON_RST   = 8'h00;
	localparam logic [7:0]  RPM_WAKE_RST    = 8'h00;
	localparam logic [7:0]  RPM_FSEL_RST    = 8'h80;
	localparam logic [7:0]  RPM_DIR_RST     = 8'hff;
	localparam logic [7:0]  RPM_DIR_DE_RST  = 8'h33;
	localparam logic [15:0] RPM_PC_RST      = 16'h0000;
	// Sync reset: {hosc, reset pin, port A}, hosc low, reset pin and port A idle high
	localparam logic [9:0]  RPM_SYNC_RST    = 10'h1ff;

	// Timing
	localparam logic [5:0]  RPM_HOSC_SWITCH_CNT = 6'd32;
	localparam int          RPM_LOW_FREQ_HZ     = 32000;

	// Operating modes
	typedef enum logic [2:0] {
		RPM_SLOW,
		RPM_SWITCH,
		RPM_FAST,
		RPM_IDLE,
		RPM_SLEEP
	} rpm_mode_t;

	// AHB-Lite request from the master
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} rpm_ahb_req_t;

	// AHB-Lite response to the master
	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} rpm_ahb_rsp_t;

	// Power and clock controls to the rest of the chip
	typedef struct packed {
		logic osc_run;
		logic hosc_run;
		logic sysclk_fast;
		logic sysclk_run;
		logic timers_run;
		logic int_service_en;
		logic pin_wake_armed;
		logic t1_wake_armed;
		logic pc_clear;
		logic wdt_clear;
		logic reg_init;
	} rpm_pwr_t;

endpackage

/* core/rpm_core.sv */
// Reset initialisation, speed and standby mode sequencer with AHB-Lite slave
// Contract
// - Any reset clears program counter to zero
// - Any reset clears the watchdog count
// - Any reset keeps or starts the oscillator
// - Pin/power reset sets both flags; watchdog clears timeout
// - Every reset reloads speed bit from option
// - Reset loads tabulated values; unimplemented bits read zero
// - Speed bit zero slow clock, one fast
// - Slow mode runs from the 32 kHz clock
// - Count 32 fast oscillator clocks before switching
// - Standby enters sleep or idle per kind bit
// - Idle stops system clock, keeps slow oscillator
// - Idle wakes on timer 1 or pin
// - Sleep stops oscillator, wakes on pin only
// - Sleep entry clears powerdown; clear and pin/power resets set it
// - Registers unchanged while in sleep
// - Timers, interrupts, wake sources per mode only
// - Standby records interrupts, defers their service
// - Each wake enable bit gates its pin
// - Timer 1 control bit 7 gates idle wake
// - Sleep entry and pin/power resets set timeout flag
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module rpm_core (
	// Clock and reset
	input  logic                 hclk,
	input  logic                 hresetn,
	// Register bus
	input  rpm_pkg::rpm_ahb_req_t ahb_req,
	output rpm_pkg::rpm_ahb_rsp_t ahb_rsp,
	// Pins from outside the clock domain
	input  logic [7:0]           porta_pin,
	input  logic                 reset_pin_n,
	input  logic                 hosc_clk_pin,
	// Events from same-clock logic
	input  logic                 wdt_timeout,
	input  logic                 timer1_underflow,
	input  logic                 irq_flag,
	// Static code option
	input  logic                 initial_speed_option,
	// Controls to the chip
	output rpm_pkg::rpm_pwr_t    pwr,
	output logic [7:0]           cpu_mode_control,
	output logic [7:0]           timer1_control
);
	import rpm_pkg::*;

	// Masked register update for bus writes
	function automatic logic [7:0] wr_mask(input logic [7:0] mask,
		input logic [31:0] data);
		wr_mask = data[7:0] & mask;
	endfunction

	// Numeric mode code for the status word
	function automatic logic [2:0] mode_code(input rpm_mode_t m);
		case (m)
			RPM_SLOW:   mode_code = 3'h0;
			RPM_SWITCH: mode_code = 3'h1;
			RPM_FAST:   mode_code = 3'h2;
			RPM_IDLE:   mode_code = 3'h3;
			RPM_SLEEP:  mode_code = 3'h4;
			default:    mode_code = 3'h7;
		endcase
	endfunction

	// Bus data phase state
	logic        dph_wr_q;          // Write data phase pending
	logic        dph_rd_q;          // Read data phase pending
	logic [11:0] dph_addr_q;        // Captured address
	rpm_ahb_rsp_t rsp_q;            // Registered response

	// Software registers
	logic [7:0]  flags_q;           // cpu_flags
	logic [7:0]  mode_q;            // cpu_mode_control
	logic [7:0]  t1con_q;           // timer1_control
	logic [7:0]  wake_en_q;         // porta_wake_enable
	logic        int_pend_q;        // Interrupt seen during standby

	// Synchronisers and filtered pin levels
	logic [9:0]  sync1_q;           // First stage
	logic [9:0]  sync2_q;           // Second stage
	logic [9:0]  sync3_q;           // Third stage
	logic [9:0]  filt_q;            // Agreed level

	// Mode sequencer
	rpm_mode_t   state_q;
	rpm_mode_t   state_d;
	logic [5:0]  cnt_q;             // Fast oscillator clocks seen
	logic        boot_q;            // First edge after power-on
	rpm_pwr_t    pwr_q;

	// Decoded events
	logic        rd_start;
	logic        wr_en;
	logic        standby;
	logic        pin_rst;
	logic        rst_init;
	logic        stby_cmd;
	logic        watchdog_clear_instruction_cmd;
	logic [7:0]  pa_fall;
	logic        hosc_rise;
	logic        pin_wake;
	logic        t1_wake;
	logic        resume_fast;
	logic        sleep_entry;
	logic [31:0] rd_mux;

	// Bus decode
	assign rd_start = ahb_req.hready & ahb_req.hsel & ahb_req.htrans[1]
		& ~ahb_req.hwrite;
	assign standby  = (state_q == RPM_IDLE) || (state_q == RPM_SLEEP);
	// Writes are dropped while the core stands by
	assign wr_en    = dph_wr_q & ahb_req.hready & ~standby;
	assign stby_cmd = wr_en && (dph_addr_q == RPM_ADDR_CMD)
		&& ahb_req.hwdata[RPM_CMD_STBY];
	assign watchdog_clear_instruction_cmd = wr_en && (dph_addr_q == RPM_ADDR_CMD)
		&& ahb_req.hwdata[RPM_CMD_WATCHDOG_CLEAR_INSTRUCTION];

	// Reset sources: power-on first edge, pin held low, watchdog
	assign pin_rst  = ~filt_q[8];
	assign rst_init = boot_q | pin_rst | wdt_timeout;

	// Edge events, counted once stages two and three agree
	assign pa_fall   = filt_q[7:0] & ~sync2_q[7:0] & ~sync3_q[7:0];
	assign hosc_rise = ~filt_q[9] & sync2_q[9] & sync3_q[9];
	// Pin wake only in standby, timer wake only in idle
	assign pin_wake  = standby && |(pa_fall & wake_en_q);
	assign t1_wake   = (state_q == RPM_IDLE) && timer1_underflow
		&& t1con_q[RPM_TIMER1_WAKE_ENABLE];
	assign resume_fast = mode_q[RPM_MS0];
	assign sleep_entry = (state_q != RPM_SLEEP) && (state_d == RPM_SLEEP);

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_q   <= 1'b0;
			dph_rd_q   <= 1'b0;
			dph_addr_q <= 12'h000;
		end else if (ahb_req.hready) begin
			dph_wr_q   <= ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hwrite;
			dph_rd_q   <= rd_start;
			dph_addr_q <= ahb_req.haddr[11:0];
		end
	end

	// Read mux; unimplemented bits and unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (dph_addr_q)
			RPM_ADDR_FLAGS: rd_mux[7:0] = flags_q;
			RPM_ADDR_MODE:  rd_mux[7:0] = mode_q & RPM_MODE_MASK;
			RPM_ADDR_T1CON: rd_mux[7:0] = t1con_q & RPM_T1CON_MASK;
			RPM_ADDR_WAKE:  rd_mux[7:0] = wake_en_q;
			RPM_ADDR_STAT:  rd_mux[7:0] = {4'h0, int_pend_q,
				mode_code(state_q)};
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// Response: reads take one wait state, writes none
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsp_q.hrdata    <= 32'h0000_0000;
			rsp_q.hreadyout <= 1'b1;
			rsp_q.hresp     <= 1'b0;
		end else if (rd_start) begin
			rsp_q.hreadyout <= 1'b0;
		end else if (dph_rd_q && !rsp_q.hreadyout) begin
			rsp_q.hrdata    <= rd_mux;
			rsp_q.hreadyout <= 1'b1;
		end
	end

	// Three-stage synchronisers for pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= RPM_SYNC_RST;
			sync2_q <= RPM_SYNC_RST;
			sync3_q <= RPM_SYNC_RST;
		end else begin
			sync1_q <= {hosc_clk_pin, reset_pin_n, porta_pin};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Agreed level follows once stages two and three match
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_q <= RPM_SYNC_RST;
		end else begin
			for (int i = 0; i < 10; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					filt_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Power-on initialisation pulse on the first edge after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	// Mode next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			// Standby kind bit picks idle or sleep
			RPM_SLOW: begin
				if (stby_cmd) begin
					state_d = mode_q[RPM_MS1] ? RPM_IDLE : RPM_SLEEP;
				end else if (mode_q[RPM_MS0]) begin
					state_d = RPM_SWITCH;
				end
			end
			RPM_SWITCH: begin
				if (stby_cmd) begin
					state_d = mode_q[RPM_MS1] ? RPM_IDLE : RPM_SLEEP;
				end else if (!mode_q[RPM_MS0]) begin
					state_d = RPM_SLOW;
				end else if (hosc_rise
					&& cnt_q == RPM_HOSC_SWITCH_CNT - 6'd1) begin
					state_d = RPM_FAST;
				end
			end
			// Clearing the speed bit drops to slow at once
			RPM_FAST: begin
				if (stby_cmd) begin
					state_d = mode_q[RPM_MS1] ? RPM_IDLE : RPM_SLEEP;
				end else if (!mode_q[RPM_MS0]) begin
					state_d = RPM_SLOW;
				end
			end
			// Idle wakes on timer 1 or a pin
			RPM_IDLE: begin
				if (pin_wake || t1_wake) begin
					state_d = resume_fast ? RPM_SWITCH : RPM_SLOW;
				end
			end
			// Sleep wakes on a pin only
			RPM_SLEEP: begin
				if (pin_wake) begin
					state_d = resume_fast ? RPM_SWITCH : RPM_SLOW;
				end
			end
			default: state_d = RPM_SLOW;
		endcase
		// Any reset restarts at the option speed
		if (rst_init) begin
			state_d = initial_speed_option ? RPM_SWITCH : RPM_SLOW;
		end
	end

	// Mode state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= RPM_SLOW;
		end else begin
			state_q <= state_d;
		end
	end

	// Fast oscillator clock counter before switch-over
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 6'd0;
		end else if (state_q != RPM_SWITCH || rst_init) begin
			cnt_q <= 6'd0;
		end else if (hosc_rise) begin
			cnt_q <= cnt_q + 6'd1;
		end
	end

	// Status flags: resets, sleep entry, watchdog clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= RPM_FLAGS_RST;
		end else if (boot_q || pin_rst) begin
			flags_q[RPM_FLAG_TO] <= 1'b1;
			flags_q[RPM_FLAG_PD] <= 1'b1;
		end else if (wdt_timeout) begin
			flags_q[RPM_FLAG_TO] <= 1'b0;
		end else begin
			// Only the low six bits take bus writes
			if (wr_en && dph_addr_q == RPM_ADDR_FLAGS) begin
				flags_q[5:0] <= ahb_req.hwdata[5:0]
					& RPM_FLAGS_WMASK[5:0];
			end
			// Watchdog clear wins over a same-cycle sleep entry
			if (watchdog_clear_instruction_cmd) begin
				flags_q[RPM_FLAG_TO] <= 1'b1;
				flags_q[RPM_FLAG_PD] <= 1'b1;
			end else if (sleep_entry) begin
				flags_q[RPM_FLAG_TO] <= 1'b1;
				flags_q[RPM_FLAG_PD] <= 1'b0;
			end
		end
	end

	// Mode control register, speed bit reloaded on every reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= RPM_MODE_RST;
		end else if (rst_init) begin
			mode_q <= {7'h00, initial_speed_option};
		end else if (wr_en && dph_addr_q == RPM_ADDR_MODE) begin
			mode_q <= wr_mask(RPM_MODE_MASK, ahb_req.hwdata);
		end
	end

	// Timer 1 control and port A wake enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t1con_q   <= RPM_T1CON_RST;
			wake_en_q <= RPM_WAKE_RST;
		end else if (rst_init) begin
			t1con_q   <= RPM_T1CON_RST;
			wake_en_q <= RPM_WAKE_RST;
		end else if (wr_en) begin
			if (dph_addr_q == RPM_ADDR_T1CON) begin
				t1con_q <= wr_mask(RPM_T1CON_MASK, ahb_req.hwdata);
			end
			if (dph_addr_q == RPM_ADDR_WAKE) begin
				wake_en_q <= wr_mask(RPM_WAKE_MASK, ahb_req.hwdata);
			end
		end
	end

	// Interrupts arriving in standby are held until wake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_pend_q <= 1'b0;
		end else if (rst_init) begin
			int_pend_q <= 1'b0;
		end else if (standby && irq_flag) begin
			int_pend_q <= 1'b1;
		end else if (!standby) begin
			int_pend_q <= 1'b0;
		end
	end

	// Registered controls from the next mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_q <= '0;
			pwr_q.osc_run <= 1'b1;
		end else begin
			pwr_q.osc_run        <= rst_init
				|| (state_d != RPM_SLEEP);
			pwr_q.hosc_run       <= (state_d == RPM_SWITCH)
				|| (state_d == RPM_FAST);
			pwr_q.sysclk_fast    <= (state_d == RPM_FAST);
			pwr_q.sysclk_run     <= !(state_d == RPM_IDLE
				|| state_d == RPM_SLEEP);
			pwr_q.timers_run     <= !(state_d == RPM_IDLE
				|| state_d == RPM_SLEEP);
			pwr_q.int_service_en <= !(state_d == RPM_IDLE
				|| state_d == RPM_SLEEP);
			pwr_q.pin_wake_armed <= (state_d == RPM_IDLE)
				|| (state_d == RPM_SLEEP);
			pwr_q.t1_wake_armed  <= (state_d == RPM_IDLE)
				&& t1con_q[RPM_TIMER1_WAKE_ENABLE];
			pwr_q.pc_clear       <= rst_init;
			pwr_q.wdt_clear      <= rst_init || watchdog_clear_instruction_cmd;
			pwr_q.reg_init       <= rst_init;
		end
	end

	// Outputs
	assign ahb_rsp          = rsp_q;
	assign pwr              = pwr_q;
	assign cpu_mode_control = mode_q;
	assign timer1_control   = t1con_q;

	// Checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_pc_clear_rst: assert property (rst_init |=> pwr_q.pc_clear)
		else $error("program counter clear missing after reset");
	chk_wdt_clear_rst: assert property (rst_init |=> pwr_q.wdt_clear)
		else $error("watchdog clear missing after reset");
	chk_osc_on_rst: assert property (rst_init |=> pwr_q.osc_run)
		else $error("oscillator not running after reset");
	chk_flags_pin_rst: assert property (pin_rst |=>
		flags_q[RPM_FLAG_TO] && flags_q[RPM_FLAG_PD])
		else $error("pin reset did not set both flags");
	chk_flags_wdt_rst: assert property (
		wdt_timeout && !pin_rst && !boot_q |=> !flags_q[RPM_FLAG_TO]
		&& flags_q[RPM_FLAG_PD] == $past(flags_q[RPM_FLAG_PD]))
		else $error("watchdog reset flags wrong");
	chk_speed_reload: assert property (
		rst_init |=> mode_q[RPM_MS0] == $past(initial_speed_option))
		else $error("speed bit not reloaded from option");
	chk_fast_after_cnt: assert property (
		$rose(state_q == RPM_FAST) |-> $past(cnt_q) == 6'd31
		&& $past(state_q) == RPM_SWITCH)
		else $error("fast mode entered before 32 clocks");
	chk_slow_clock_sel: assert property (
		state_q == RPM_SLOW && !boot_q
		|-> !pwr_q.sysclk_fast && pwr_q.sysclk_run)
		else $error("slow mode not on low frequency clock");
	chk_sleep_entry: assert property (
		sleep_entry && !watchdog_clear_instruction_cmd |=> !flags_q[RPM_FLAG_PD]
		&& flags_q[RPM_FLAG_TO] && !pwr_q.osc_run)
		else $error("sleep entry flags or oscillator wrong");
	chk_sleep_hold: assert property (
		state_q == RPM_SLEEP && !pin_wake && !rst_init
		|=> state_q == RPM_SLEEP)
		else $error("sleep left without pin wake");
	chk_idle_t1_wake: assert property (
		state_q == RPM_IDLE && timer1_underflow && t1con_q[RPM_TIMER1_WAKE_ENABLE]
		&& !rst_init |=> state_q == (mode_q[RPM_MS0] ? RPM_SWITCH
		: RPM_SLOW))
		else $error("idle did not wake on timer 1");
	chk_regs_frozen: assert property (
		standby && !rst_init |=> $stable(wake_en_q) && $stable(mode_q))
		else $error("register changed during standby");
	chk_int_deferred: assert property (
		standby |-> !pwr_q.int_service_en && !pwr_q.timers_run
		&& !pwr_q.sysclk_run)
		else $error("interrupt service active in standby");

endmodule

/* verif/rpm_far_model.sv */
// Far-side model: port A wake pins, fast oscillator and timer 1
`timescale 1ns/1ps

module rpm_far_model (
	// Clock and controls from the block
	input  wire logic              hclk,
	input  wire rpm_pkg::rpm_pwr_t pwr,
	// Pins and events toward the block
	output logic [7:0]             porta_pin,
	output logic                   hosc_clk_pin,
	output logic                   timer1_underflow,
	// Fast clock rising edges since its enable rose
	output int                     hosc_edges
);
	import rpm_pkg::*;

	// Pins idle high through their pull-ups
	initial begin
		porta_pin        = 8'hff;
		hosc_clk_pin     = 1'b0;
		timer1_underflow = 1'b0;
		hosc_edges       = 0;
	end

	// Fast oscillator runs only while enabled, phase unrelated to hclk
	always begin
		#6.5;
		if (pwr.hosc_run === 1'b1) begin
			hosc_clk_pin = ~hosc_clk_pin;
			if (hosc_clk_pin) hosc_edges++;
		end else begin
			hosc_clk_pin = 1'b0;
			hosc_edges   = 0;
		end
	end

	// Falling edge on one pin, held long enough to pass the synchroniser
	task automatic press(input int pin);
		@(posedge hclk);
		porta_pin[pin] <= 1'b0;
		repeat (8) @(posedge hclk);
		porta_pin[pin] <= 1'b1;
	endtask

	// One-cycle underflow pulse
	task automatic underflow();
		@(posedge hclk);
		timer1_underflow <= 1'b1;
		@(posedge hclk);
		timer1_underflow <= 1'b0;
	endtask
endmodule

/* verif/reset_init_and_power_modes_bench.sv */
// Self-checking bench for the reset and power mode sequencer
`timescale 1ns/1ps

module reset_init_and_power_modes_bench;
	import rpm_pkg::*;

	// Bus master signals
	logic                hclk, hresetn, hsel, hwrite;
	logic [31:0]         haddr, hwdata;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	rpm_ahb_req_t        ahb_req;
	rpm_ahb_rsp_t        ahb_rsp;
	// Pins, events and outputs
	logic [7:0]          porta_pin, mode_reg, t1_reg;
	logic                reset_pin_n, hosc_clk_pin, wdt_timeout;
	logic                timer1_underflow, irq_flag, initial_speed_option;
	rpm_pwr_t            pwr;
	// Bookkeeping
	int                  n_mismatch, checks, n_init, hosc_edges;

	assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hwdata,
		ahb_rsp.hreadyout};

	rpm_core dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
		.ahb_rsp(ahb_rsp), .porta_pin(porta_pin),
		.reset_pin_n(reset_pin_n), .hosc_clk_pin(hosc_clk_pin),
		.wdt_timeout(wdt_timeout), .timer1_underflow(timer1_underflow),
		.irq_flag(irq_flag), .initial_speed_option(initial_speed_option),
		.pwr(pwr), .cpu_mode_control(mode_reg), .timer1_control(t1_reg));

	rpm_far_model far (.hclk(hclk), .pwr(pwr), .porta_pin(porta_pin),
		.hosc_clk_pin(hosc_clk_pin), .timer1_underflow(timer1_underflow),
		.hosc_edges(hosc_edges));

	// Clock, 5 ns period
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// Counts init pulses: counter clear, watchdog clear, register load
	always @(posedge hclk) begin
		if (pwr.pc_clear === 1'b1 && pwr.wdt_clear === 1'b1 &&
			pwr.reg_init === 1'b1) n_init <= n_init + 1;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	// One single AHB-Lite transfer, waits on hready in both phases
	task automatic bus(input logic [11:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd_o);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
		rd_o = ahb_rsp.hrdata;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(a, 1'b0, 32'h0, x);
		chk(x, e);
	endtask

	// Mode field of the status word, now or after polling
	task automatic mode_chk(input logic [2:0] m, input int polls);
		logic [31:0] x;
		for (int i = 0; i < polls; i++) begin
			bus(RPM_ADDR_STAT, 1'b0, 32'h0, x);
			if (x[2:0] === m) break;
		end
		chk({29'h0, x[2:0]}, {29'h0, m});
	endtask

	// Values after power-on release
	task automatic t_reset_values();
		rd_chk(RPM_ADDR_FLAGS, 32'hc0);
		rd_chk(RPM_ADDR_MODE, 32'h0);
		rd_chk(RPM_ADDR_T1CON, 32'h0);
		rd_chk(RPM_ADDR_WAKE, 32'h0);
		rd_chk(12'h3f0, 32'h0);
		chk(n_init, 1);
		chk({31'h0, pwr.osc_run}, 1);
		chk({31'h0, pwr.sysclk_fast}, 0);
	endtask

	// Unimplemented and read-only bits
	task automatic t_masks();
		wr(RPM_ADDR_T1CON, 32'hffff_ffff);
		rd_chk(RPM_ADDR_T1CON, 32'h9b);
		chk({24'h0, t1_reg}, 32'h9b);
		wr(RPM_ADDR_FLAGS, 32'h0);
		rd_chk(RPM_ADDR_FLAGS, 32'hc0);
		wr(RPM_ADDR_WAKE, 32'ha5);
		rd_chk(RPM_ADDR_WAKE, 32'ha5);
		wr(RPM_ADDR_MODE, 32'hff);
		rd_chk(RPM_ADDR_MODE, 32'h07);
		chk({24'h0, mode_reg}, 32'h07);
		wr(RPM_ADDR_MODE, 32'h0);
		@(posedge hclk);
		wr(RPM_ADDR_T1CON, 32'h0);
	endtask

	// Slow to fast through the 32-clock count, and back
	task automatic t_speed();
		wr(RPM_ADDR_MODE, 32'h1);
		mode_chk(RPM_SWITCH, 1);
		mode_chk(RPM_FAST, 200);
		chk({31'h0, hosc_edges >= 32}, 1);
		chk({31'h0, pwr.hosc_run}, 1);
		chk({31'h0, pwr.sysclk_fast}, 1);
		wr(RPM_ADDR_MODE, 32'h0);
		@(posedge hclk);
		mode_chk(RPM_SLOW, 4);
		chk({30'h0, pwr.sysclk_run, pwr.sysclk_fast}, 2);
	endtask

	// Idle entry, deferred interrupt, timer and pin wake
	task automatic t_idle();
		wr(RPM_ADDR_WAKE, 32'h1);
		wr(RPM_ADDR_T1CON, 32'h80);
		wr(RPM_ADDR_MODE, 32'h2);
		wr(RPM_ADDR_CMD, 32'h1);
		mode_chk(RPM_IDLE, 1);
		chk({30'h0, pwr.sysclk_run, pwr.osc_run}, 1);
		chk({30'h0, pwr.timers_run, pwr.t1_wake_armed}, 1);
		irq_flag <= 1'b1;
		@(posedge hclk);
		irq_flag <= 1'b0;
		rd_chk(RPM_ADDR_STAT, 32'hb);
		chk({31'h0, pwr.int_service_en}, 0);
		far.underflow();
		mode_chk(RPM_SLOW, 10);
		chk({31'h0, pwr.int_service_en}, 1);
		wr(RPM_ADDR_T1CON, 32'h0);
		wr(RPM_ADDR_CMD, 32'h1);
		far.underflow();
		mode_chk(RPM_IDLE, 1);
		far.press(0);
		mode_chk(RPM_SLOW, 10);
	endtask

	// Sleep entry, flags, refused wakes and pin wake
	task automatic t_sleep();
		wr(RPM_ADDR_T1CON, 32'h80);
		wr(RPM_ADDR_MODE, 32'h0);
		wr(RPM_ADDR_CMD, 32'h1);
		rd_chk(RPM_ADDR_FLAGS, 32'h80);
		chk({31'h0, pwr.osc_run}, 0);
		chk({30'h0, pwr.pin_wake_armed, pwr.t1_wake_armed}, 2);
		wr(RPM_ADDR_WAKE, 32'hff);
		far.underflow();
		far.press(1);
		mode_chk(RPM_SLEEP, 1);
		far.press(0);
		mode_chk(RPM_SLOW, 10);
		rd_chk(RPM_ADDR_WAKE, 32'h1);
		wr(RPM_ADDR_CMD, 32'h2);
		rd_chk(RPM_ADDR_FLAGS, 32'hc0);
	endtask

	// Watchdog timeout after sleep keeps powerdown clear
	task automatic t_wdt();
		int k;
		wr(RPM_ADDR_CMD, 32'h1);
		far.press(0);
		mode_chk(RPM_SLOW, 10);
		k = n_init;
		wdt_timeout <= 1'b1;
		@(posedge hclk);
		wdt_timeout <= 1'b0;
		rd_chk(RPM_ADDR_FLAGS, 32'h0);
		chk(n_init, k + 1);
		rd_chk(RPM_ADDR_WAKE, 32'h0);
		rd_chk(RPM_ADDR_T1CON, 32'h0);
	endtask

	// Reset pin with the fast start option
	task automatic t_pin_reset();
		int k;
		k = n_init;
		initial_speed_option <= 1'b1;
		reset_pin_n <= 1'b0;
		repeat (8) @(posedge hclk);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge hclk);
		rd_chk(RPM_ADDR_MODE, 32'h1);
		rd_chk(RPM_ADDR_FLAGS, 32'hc0);
		chk({31'h0, n_init > k}, 1);
		mode_chk(RPM_FAST, 200);
	endtask

	// Verdict and end of run
	task automatic close_out();
		if (n_mismatch == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		reset_pin_n = 1'b1;
		wdt_timeout = 1'b0;
		irq_flag = 1'b0;
		initial_speed_option = 1'b0;
		n_mismatch = 0;
		checks = 0;
		n_init = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_values();
		t_masks();
		t_speed();
		t_idle();
		t_sleep();
		t_wdt();
		t_pin_reset();
		close_out();
	end

	// Hang guard, far beyond the expected run of about a thousand cycles
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
endmodule
